// ---- dv/host_bus_model.sv ----
// host address source standing in for the expansion bus
// assumes the decoder takes one address per clk_i edge
`timescale 1ns/1ns
module host_bus_model (
    input wire clk_i,
    output reg valid_o,
    output reg io_o,
    output reg [31:0] addr_o
);
    initial begin
        valid_o = 0;
        io_o = 0;
        addr_o = 0;
    end
    // lookups only, never a config write, one instance with no legacy decode
    task send(input o, input [31:0] a);
        begin
            @(posedge clk_i);
            valid_o <= 1;
            io_o <= o;
            addr_o <= a;
            @(posedge clk_i);
            valid_o <= 0;
            // released lines show junk so a stale address cannot pass
            addr_o <= ~a;
        end
    endtask
endmodule

// ---- dv/slot_config_address_decode_checker.sv ----
// assertions on the config bus and host decode ports
// assumes straps stay steady while host addresses run
`timescale 1ns/1ns
module slot_config_address_decode_checker (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire [7:0] strap_placement_i,
    input wire [7:0] strap_aperture_i,
    input wire host_valid_i,
    input wire host_io_i,
    input wire [31:0] host_addr_i,
    input wire host_done_o,
    input wire io_hit_o,
    input wire rom_hit_o,
    input wire coproc_hit_o,
    input wire aperture_hit_o,
    input wire [3:0] io_reg_o,
    input wire [6:0] coproc_reg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [31:0] a = host_addr_i;
    wire [7:0] p = strap_placement_i;
    wire [7:0] v = strap_aperture_i;
    wire q = host_valid_i && p[0];
    wire m = q && !host_io_i;
    wire hits = io_hit_o | rom_hit_o | coproc_hit_o | aperture_hit_o;
    reg [31:0] pa;
    // no reset needed, only read after a valid cycle
    always @(posedge clk_i) pa <= a;
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("access not acked");
    done_pulse_a: assert property (host_done_o == $past(host_valid_i)) else $error("done misplaced");
    decode_off_a: assert property (host_valid_i && !p[0] |=> !hits) else $error("hit while off");
    io_hit_a: assert property (q && host_io_i && a[31:4] == {16'h0, 9'h042, p[3:1]} |=> io_hit_o)
        else $error("io bank missed");
    rom_hit_a: assert property (m && a[31:13] == {15'h6, p[7:4]} && a[12:10] != 3'h7 |=> rom_hit_o)
        else $error("rom missed");
    coproc_hit_a: assert property (m && a[31:7] == {15'h6, p[7:4], 3'h7, p[3:1]} |=> coproc_hit_o)
        else $error("coproc missed");
    aperture_a: assert property (m && v[0] && a[31:22] == {v[7:1], p[3:1]} |=> aperture_hit_o)
        else $error("aperture missed");
    aperture_off_a: assert property (host_valid_i && !v[0] |=> !aperture_hit_o) else $error("aperture hit");
    reg_index_a: assert property (host_valid_i |=> io_reg_o == pa[3:0] && coproc_reg_o == pa[6:0])
        else $error("index wrong");
endmodule
bind slot_config_address_decode slot_config_address_decode_checker chk_i (.*);

// ---- dv/tb_slot_config_address_decode.sv ----
// self-checking bench: config reads and host decode
// assumes host_bus_model drives the host address stream
`timescale 1ns/1ns
module tb_slot_config_address_decode;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    reg [7:0] adr_i = 8'h00, strap_placement_i = 8'h00, strap_aperture_i = 8'h00;
    reg [3:0] sel_i = 4'hf;
    reg [31:0] dat_i = 32'h0, rd;
    wire [31:0] dat_o, host_addr_i;
    wire [3:0] io_reg_o;
    wire [6:0] coproc_reg_o;
    wire ack_o, host_valid_i, host_io_i, host_done_o, io_hit_o, rom_hit_o, coproc_hit_o, aperture_hit_o;
    wire [3:0] mask = strap_placement_i[0] ? {strap_aperture_i[0], 3'h7} : 4'h0;
    integer num_errors = 0, checks = 0, i, k;
    always #10 clk_i = ~clk_i;
    // id bytes are arbitrary
    slot_config_address_decode #(.ID_LOW(8'h11), .ID_HIGH(8'h22)) DUT (.*);
    host_bus_model m (.clk_i(clk_i), .valid_o(host_valid_i), .io_o(host_io_i), .addr_o(host_addr_i));
    task chk(input [31:0] s, input [31:0] e, input string n);
        begin
            checks = checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("BAD %s exp %h got %h", n, e, s);
            end
        end
    endtask
    task give_verdict;
        begin
            if (num_errors == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc_i <= 1;
            stb_i <= 1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            for (k = 0; k < 9 && ack_o !== 1'b1; k = k + 1) @(posedge clk_i);
            if (ack_o !== 1'b1) begin
                chk(ack_o, 1, "ack");
                give_verdict;
            end
            rd = dat_o;
            cyc_i <= 0;
            stb_i <= 0;
        end
    endtask
    task boot(input [7:0] p, input [7:0] v);
        begin
            if (rst_i !== 1'b1) @(posedge clk_i);
            rst_i <= 1;
            strap_placement_i <= p;
            strap_aperture_i <= v;
            repeat (4) @(posedge clk_i);
            rst_i <= 0;
            rd = 0;
            for (i = 0; i < 9 && rd[0] !== 1'b1; i = i + 1) wb(0, 8'h2c, 0);
            if (rd[0] !== 1'b1) begin
                chk(rd, 1, "settle");
                give_verdict;
            end
        end
    endtask
    task d(input o, input [31:0] a, input [3:0] e);
        begin
            m.send(o, a);
            #1;
            chk(host_done_o, 1, "done");
            chk({aperture_hit_o, coproc_hit_o, rom_hit_o, io_hit_o}, e & mask, "hit");
            chk({coproc_reg_o, io_reg_o}, {a[6:0], a[3:0]}, "index");
        end
    endtask
    task run(input [7:0] p, input [7:0] v);
        reg [39:0] e;
        begin
            boot(p, v);
            e = {v, 8'h00, p, 8'h22, 8'h11};
            for (i = 0; i < 5; i = i + 1) begin
                wb(1, {i[5:0], 2'b00}, 32'hffffffff);
                wb(0, {i[5:0], 2'b00}, 0);
                chk(rd, {24'h0, e[i*8 +: 8]}, "reg");
            end
            d(1, 32'h00002160, 4'h1);
            d(1, 32'h0000216f, 4'h1);
            d(1, 32'h00002150, 4'h0);
            d(0, 32'h000ca000, 4'h2);
            d(0, 32'h000cbbff, 4'h2);
            d(0, 32'h000cbf00, 4'h4);
            d(0, 32'h000cbf7f, 4'h4);
            d(0, 32'h000cbe80, 4'h0);
            d(0, 32'h03800000, 4'h8);
            d(0, 32'h03400000, 4'h0);
            wb(1, 8'h20, 32'h00002160);
            wb(1, 8'h24, 32'h00000001);
            wb(0, 8'h20, 0);
            chk(rd, 32'h00002160, "lookup addr");
            wb(0, 8'h24, 0);
            chk(rd & 32'h1, 32'h1, "lookup io");
            wb(0, 8'h28, 0);
            chk(rd, {28'h0, 4'h1 & mask}, "lookup io hit");
            wb(1, 8'h24, 32'h00000000);
            wb(1, 8'h20, 32'h03800000);
            wb(0, 8'h28, 0);
            chk(rd, {28'h0, 4'h8 & mask}, "lookup aperture");
        end
    endtask
    initial begin
        run(8'h5d, 8'h03);
        run(8'h5c, 8'h03);
        run(8'h5d, 8'h02);
        give_verdict;
    end
endmodule

// ---- verilog/slot_config_address_decode.v ----
// slot configuration registers and the address decode they steer
// assumes a classic wishbone master on clk_i, straps that are quasi-static
// pins, and a host address stream clocked on clk_i
`timescale 1ns/1ns
`include "slot_config_defs.vh"

module slot_config_address_decode #(
    parameter [7:0] ID_LOW = 8'h5a, // arbitrary value, not a maker's code
    parameter [7:0] ID_HIGH = 8'h3c // arbitrary value, not a maker's code
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire [7:0] strap_placement_i,
    input wire [7:0] strap_aperture_i,
    input wire host_valid_i,
    input wire host_io_i,
    input wire [31:0] host_addr_i,
    output reg host_done_o,
    output reg io_hit_o,
    output reg rom_hit_o,
    output reg coproc_hit_o,
    output reg aperture_hit_o,
    output reg [3:0] io_reg_o,
    output reg [6:0] coproc_reg_o
);

    // address matchers, one per window the host can hit

    // io bank: 16 registers at 2100 hex plus 10 hex per instance
    function io_match;
        input [31:0] addr;
        input [2:0] inst;
        begin
            io_match = (addr[31:16] == 16'h0000)
                && (addr[15:7] == `IO_BANK_TOP)
                && (addr[6:4] == inst);
        end
    endfunction

    // the 8 Kbyte block picked by the rom select
    function rom_block;
        input [31:0] addr;
        input [3:0] rom;
        begin
            rom_block = (addr[31:17] == `ROM_AREA_TOP)
                && (addr[16:13] == rom);
        end
    endfunction

    // first 7 Kbyte of the block belong to the rom
    function rom_match;
        input [31:0] addr;
        input [3:0] rom;
        begin
            rom_match = rom_block(addr, rom)
                && (addr[12:10] != `COPROC_SECTION);
        end
    endfunction

    // last Kbyte, one 128-byte section per instance
    function coproc_match;
        input [31:0] addr;
        input [3:0] rom;
        input [2:0] inst;
        begin
            coproc_match = rom_block(addr, rom)
                && (addr[12:10] == `COPROC_SECTION)
                && (addr[9:7] == inst);
        end
    endfunction

    // 4 Mbyte window: seven base bits, then the instance
    function aperture_match;
        input [31:0] addr;
        input [7:0] apert;
        input [2:0] inst;
        begin
            aperture_match = apert[`BIT_APERTURE_EN]
                && (addr[31:25] == apert[`BIT_VMBASE_HI:`BIT_VMBASE_LO])
                && (addr[24:22] == inst);
        end
    endfunction

    // decode one address against the captured placement
    function [3:0] decode;
        input [31:0] addr;
        input is_io;
        input [7:0] place;
        input [7:0] apert;
        reg [2:0] inst;
        reg [3:0] rom;
        begin
            inst = place[`BIT_INST_HI:`BIT_INST_LO];
            rom = place[`BIT_ROM_HI:`BIT_ROM_LO];
            decode = 4'h0;
            if (is_io) begin
                decode[`HIT_IO] = io_match(addr, inst);
            end else begin
                decode[`HIT_ROM] = rom_match(addr, rom);
                decode[`HIT_COPROC] = coproc_match(addr, rom, inst);
                decode[`HIT_APERTURE] = aperture_match(addr, apert, inst);
            end
            // with decode off only the configuration registers answer
            if (!place[`BIT_DECODE_EN]) begin
                decode = 4'h0;
            end
        end
    endfunction

    // byte lanes of a write land only where sel_i is set
    function [31:0] merge_lanes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] sel;
        integer b;
        begin
            merge_lanes = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge_lanes[b*8 +: 8] = data[b*8 +: 8];
                end
            end
        end
    endfunction

    // strap synchroniser, first stage read only by the second
    // straps are slow pins, so two flops keep metastability out of the decode
    reg [7:0] place_meta;
    reg [7:0] place_sync;
    reg [7:0] apert_meta;
    reg [7:0] apert_sync;

    always @(posedge clk_i) begin
        place_meta <= strap_placement_i;
        place_sync <= place_meta;
        apert_meta <= strap_aperture_i;
        apert_sync <= apert_meta;
    end

    // configuration is captured once after reset and then frozen;
    // later strap moves are ignored, so a placement change needs a reset
    localparam [1:0] ST_SETTLE = 2'b01;
    localparam [1:0] ST_FROZEN = 2'b10;

    reg [7:0] placement;
    reg [7:0] aperture;
    reg [1:0] settle;
    reg [1:0] state;
    reg [1:0] next_state;
    wire captured;

    assign captured = (state == ST_FROZEN);

    // settle covers the two synchroniser flops with a cycle to spare
    always @* begin
        next_state = state;
        case (state)
            ST_SETTLE: begin
                if (settle == `STRAP_SETTLE) begin
                    next_state = ST_FROZEN;
                end
            end
            ST_FROZEN: begin
                next_state = ST_FROZEN;
            end
            default: begin
                next_state = ST_SETTLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_SETTLE;
            settle <= 2'h0;
            placement <= `RST_PLACEMENT;
            aperture <= `RST_APERTURE;
        end else begin
            state <= next_state;
            if (state == ST_SETTLE) begin
                settle <= settle + 2'h1;
            end
            if ((state == ST_SETTLE) && (next_state == ST_FROZEN)) begin
                placement <= place_sync;
                aperture <= apert_sync;
            end
        end
    end

    // register bus
    wire [5:0] index;
    wire bus_req;
    wire wr_low;
    reg [31:0] lookup_addr;
    reg lookup_io;
    reg [31:0] next_dat;
    wire [3:0] lookup_result;

    assign index = adr_i[7:2];
    assign bus_req = cyc_i && stb_i && !ack_o;
    // a write lands at the edge that shows ack to the master,
    // the one edge at which the master counts it as done
    assign wr_low = cyc_i && stb_i && we_i && ack_o;
    assign lookup_result = decode(lookup_addr, lookup_io, placement, aperture);

    // 8-bit registers sit in byte lane 0, upper bits read zero
    // placement and aperture reads come from captured straps, never from the bus
    always @* begin
        next_dat = 32'h00000000;
        case (index)
            `IDX_ID_LOW: begin
                next_dat[7:0] = ID_LOW;
            end
            `IDX_ID_HIGH: begin
                next_dat[7:0] = ID_HIGH;
            end
            `IDX_PLACEMENT: begin
                next_dat[7:0] = placement;
            end
            `IDX_APERTURE: begin
                next_dat[7:0] = aperture;
            end
            `IDX_LOOKUP_ADDR: begin
                next_dat = lookup_addr;
            end
            `IDX_LOOKUP_CTRL: begin
                next_dat[0] = lookup_io;
            end
            `IDX_LOOKUP_RESULT: begin
                next_dat[3:0] = lookup_result;
            end
            `IDX_STATUS: begin
                next_dat[0] = captured;
            end
            default: begin
                next_dat = 32'h00000000;
            end
        endcase
    end

    // every access is answered one cycle later, unmapped ones read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                dat_o <= next_dat;
            end
        end
    end

    // only the lookup registers take writes; configuration ignores them
    always @(posedge clk_i) begin
        if (rst_i) begin
            lookup_addr <= `RST_LOOKUP_ADDR;
            lookup_io <= `RST_LOOKUP_CTRL;
        end else if (wr_low) begin
            if (index == `IDX_LOOKUP_ADDR) begin
                lookup_addr <= merge_lanes(lookup_addr, dat_i, sel_i);
            end
            if ((index == `IDX_LOOKUP_CTRL) && sel_i[0]) begin
                lookup_io <= dat_i[0];
            end
        end
    end
    // writes to indices 0..4 fall through untouched

    // host decode path, one registered answer per valid address
    wire [3:0] host_result;
    reg next_io_hit;
    reg next_rom_hit;
    reg next_coproc_hit;
    reg next_aperture_hit;
    reg [3:0] next_io_reg;
    reg [6:0] next_coproc_reg;

    assign host_result = decode(host_addr_i, host_io_i, placement, aperture);

    // hits are held low between requests so a stale match never lingers
    always @* begin
        next_io_hit = 1'b0;
        next_rom_hit = 1'b0;
        next_coproc_hit = 1'b0;
        next_aperture_hit = 1'b0;
        next_io_reg = io_reg_o;
        next_coproc_reg = coproc_reg_o;
        if (host_valid_i) begin
            next_io_hit = host_result[`HIT_IO];
            next_rom_hit = host_result[`HIT_ROM];
            next_coproc_hit = host_result[`HIT_COPROC];
            next_aperture_hit = host_result[`HIT_APERTURE];
            next_io_reg = host_addr_i[3:0];
            next_coproc_reg = host_addr_i[6:0];
        end
    end

    // done pulses even with decode off, so the host can tell a miss from a stall
    always @(posedge clk_i) begin
        if (rst_i) begin
            host_done_o <= 1'b0;
            io_hit_o <= 1'b0;
            rom_hit_o <= 1'b0;
            coproc_hit_o <= 1'b0;
            aperture_hit_o <= 1'b0;
            io_reg_o <= 4'h0;
            coproc_reg_o <= 7'h00;
        end else begin
            host_done_o <= host_valid_i;
            io_hit_o <= next_io_hit;
            rom_hit_o <= next_rom_hit;
            coproc_hit_o <= next_coproc_hit;
            aperture_hit_o <= next_aperture_hit;
            io_reg_o <= next_io_reg;
            coproc_reg_o <= next_coproc_reg;
        end
    end

endmodule

// ---- verilog/slot_config_defs.vh ----
// constants for the slot configuration bank and its address decode
// assumes a 32-bit classic wishbone slave with the word index in adr_i[7:2]
`ifndef SLOT_CONFIG_DEFS_VH
`define SLOT_CONFIG_DEFS_VH

// register indices, byte address is four times the index
`define IDX_ID_LOW 6'h00
`define IDX_ID_HIGH 6'h01
`define IDX_PLACEMENT 6'h02
`define IDX_APERTURE 6'h04
`define IDX_LOOKUP_ADDR 6'h08
`define IDX_LOOKUP_CTRL 6'h09
`define IDX_LOOKUP_RESULT 6'h0a
`define IDX_STATUS 6'h0b

// decode_placement_config fields
`define BIT_DECODE_EN 0
`define BIT_INST_LO 1
`define BIT_INST_HI 3
`define BIT_ROM_LO 4
`define BIT_ROM_HI 7

// video_aperture_config fields
`define BIT_APERTURE_EN 0
`define BIT_VMBASE_LO 1
`define BIT_VMBASE_HI 7

// reset values, decode stays off until the straps are captured
`define RST_PLACEMENT 8'h00
`define RST_APERTURE 8'h00
`define RST_LOOKUP_ADDR 32'h00000000
`define RST_LOOKUP_CTRL 1'b0

// io bank: 16 registers from 2100 hex, 10 hex apart
`define IO_BANK_TOP 9'h042
// rom blocks: 8 Kbyte each from c0000 hex
`define ROM_AREA_TOP 15'h0006
// final 1 Kbyte of a rom block holds the coprocessor banks
`define COPROC_SECTION 3'h7

// result bit positions
`define HIT_IO 0
`define HIT_ROM 1
`define HIT_COPROC 2
`define HIT_APERTURE 3

// cycles the strap synchroniser needs before capture
`define STRAP_SETTLE 2'h3

`endif
